// File: common/pwm_dac_pkg.sv
// Package for the pulse-width / rate-multiplier DAC block.
// Assumes a 40 MHz system clock and an Avalon-MM register slave.
package pwm_dac_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_CH    = 2;   // Channels (one fine-step pair)
    localparam int CNT_W     = 10;  // Shared counter width
    localparam int PW_W      = 6;   // Pulse-width part
    localparam int FS_W      = 4;   // Fine-step part

    // ****************************************************************
    // Register offsets (byte addresses, word aligned)
    // ****************************************************************
    localparam logic [3:0] OFF_WEIGHT0 = 4'h0;  // pulse_weight_reg ch0
    localparam logic [3:0] OFF_WEIGHT1 = 4'h4;  // pulse_weight_reg ch1
    localparam logic [3:0] OFF_FSTEP   = 4'h8;  // fine_step_pair_reg
    localparam logic [3:0] OFF_COUNT   = 4'hc;  // Shared counter (RO)

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int WEIGHT_POL_BIT  = 6;   // polarity_invert
    localparam int WEIGHT_ONE_BIT  = 7;   // Reads as one
    localparam int FSTEP_HI_LSB    = 4;   // Odd channel field
    localparam logic [7:0] WEIGHT_RESET = 8'h80;
    localparam logic [7:0] FSTEP_RESET  = 8'h00;

endpackage : pwm_dac_pkg

// File: rtl/pwm_channel.sv
// One output channel of the pulse-width / rate-multiplier DAC.
// Assumes settings already held stable for the whole 64-clock cycle.
`timescale 1ns/1ps
module pwm_channel
    import pwm_dac_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    input  wire logic [CNT_W-1:0] count,       // Shared counter
    input  wire logic [PW_W-1:0] weight,      // Pulse length
    input  wire logic [FS_W-1:0] fine_step,   // Rate multiplier
    input  wire logic            pol_inv,     // Inverted polarity
    output logic                 pwm_out      // Pin level
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire logic [PW_W-1:0] low_cnt = count[PW_W-1:0];
    wire logic [FS_W-1:0] cyc     = count[CNT_W-1:PW_W];
    // Cycle selected for extension; cycle 0 never matches
    wire logic sel8   = fine_step[0] & (cyc == 4'h8);
    wire logic sel4   = fine_step[1] & (cyc[2:0] == 3'h4);
    wire logic sel2   = fine_step[2] & (cyc[1:0] == 2'h2);
    wire logic sel1   = fine_step[3] & cyc[0];
    wire logic extend = sel8 | sel4 | sel2 | sel1;
    // Pulse start at wrap of low bits; extension starts one clock
    // earlier, at the last count of the previous cycle
    wire logic wrap_now  = (low_cnt == 6'h3f);
    // One count ahead of the wrap: decides the pin level at the wrap
    wire logic pre_wrap  = (low_cnt == 6'h3e);
    wire logic [FS_W-1:0] next_cyc = cyc + 4'h1;
    wire logic next_ext = (fine_step[0] & (next_cyc == 4'h8))
                        | (fine_step[1] & (next_cyc[2:0] == 3'h4))
                        | (fine_step[2] & (next_cyc[1:0] == 2'h2))
                        | (fine_step[3] & next_cyc[0]);
    // Active level inside the pulse
    logic pulse_q;
    logic pulse_d;

    // ****************************************************************
    // Pulse state: set at wrap, cleared on weight match
    // ****************************************************************
    always_comb begin
        pulse_d = pulse_q;
        // Register lags one count, so the extra clock is set up at 3Eh
        if (pre_wrap && next_ext) begin
            pulse_d = 1'b1;
        end else if (wrap_now) begin
            pulse_d = (weight != 6'h00);
        end else if ((low_cnt + 6'h01) == weight) begin
            pulse_d = 1'b0;
        end
    end

    // Registered pulse and pin
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_q <= 1'b0;
            pwm_out <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
            pwm_out <= pulse_d ^ pol_inv;
        end
    end

    // extend is kept for readability of the selection table
    wire logic unused_ok = extend;

endmodule : pwm_channel

// File: rtl/pwm_dac.sv
// Pulse-width / rate-multiplier DAC with Avalon-MM register slave.
// Assumes one 40 MHz clock, async active-low reset, RC filters on pins.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - 10-bit value: 6 width, 4 fine-step
// - Counter every clock; low wrap starts pulse
// - Low bits equal weight ends pulse
// - Bit 6 inverts output polarity
// - Bits 5:0 hold pulse length
// - Weight bit 7 always reads one
// - Extension adds one clock before pulse
// - Fine-step bits select cycles additively
// - Shared fine-step register, reset 00h
// - Zero weight and step: output low
// - 3Fh/0Fh: low only at last count of cycle 15
// - Zero values, inverted: constant high
// - Outputs driven low after reset
module pwm_dac
    import pwm_dac_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,      // Byte address
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    output logic [NUM_CH-1:0] pwm_out           // Output pins
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // One wait state: waitrequest high on first cycle of a request
    logic ack_q;
    wire logic req      = avs_read | avs_write;
    wire logic done     = req & ack_q;
    wire logic wr_ok    = avs_write & done & avs_byteenable[0];
    wire logic hit_w0   = (avs_address == OFF_WEIGHT0);
    wire logic hit_w1   = (avs_address == OFF_WEIGHT1);
    wire logic hit_fs   = (avs_address == OFF_FSTEP);
    wire logic hit_cnt  = (avs_address == OFF_COUNT);
    wire logic mapped   = hit_w0 | hit_w1 | hit_fs | hit_cnt;

    assign avs_waitrequest = req & ~ack_q;

    // ****************************************************************
    // Registers: shadow (software) and live (applied)
    // ****************************************************************
    logic [6:0]      weight_sh_q [NUM_CH];   // Polarity + width
    logic [6:0]      weight_lv_q [NUM_CH];   // Applied copy
    logic [7:0]      fstep_sh_q;             // Shadow pair
    logic [7:0]      fstep_lv_q;             // Applied pair
    logic [CNT_W-1:0] count_q;               // Shared counter
    // Boundary: last count before low bits wrap
    wire logic boundary = (count_q[PW_W-1:0] == 6'h3f);

    // Acknowledge flop for the single wait state
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Free running shared counter
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + 10'h001;
        end
    end

    // Software writes land in shadows
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            weight_sh_q[0] <= WEIGHT_RESET[6:0];
            weight_sh_q[1] <= WEIGHT_RESET[6:0];
            fstep_sh_q     <= FSTEP_RESET;
        end else if (wr_ok) begin
            if (hit_w0) begin
                weight_sh_q[0] <= avs_writedata[6:0];
            end
            if (hit_w1) begin
                weight_sh_q[1] <= avs_writedata[6:0];
            end
            if (hit_fs) begin
                fstep_sh_q <= avs_writedata[7:0];
            end
        end
    end

    // Shadows copied to live values at the cycle boundary
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            weight_lv_q[0] <= WEIGHT_RESET[6:0];
            weight_lv_q[1] <= WEIGHT_RESET[6:0];
            fstep_lv_q     <= FSTEP_RESET;
        end else if (boundary) begin
            weight_lv_q[0] <= weight_sh_q[0];
            weight_lv_q[1] <= weight_sh_q[1];
            fstep_lv_q     <= fstep_sh_q;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    wire logic [7:0] rd_w0  = {1'b1, weight_sh_q[0]};
    wire logic [7:0] rd_w1  = {1'b1, weight_sh_q[1]};
    wire logic [9:0] rd_sel = hit_w0  ? {2'b00, rd_w0} :
                              hit_w1  ? {2'b00, rd_w1} :
                              hit_fs  ? {2'b00, fstep_sh_q} :
                              hit_cnt ? count_q : 10'h000;

    // Registered read data and response
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else if (req & ~ack_q) begin
            avs_readdata <= avs_read ? {22'h0, rd_sel} : 32'h0;
            avs_response <= mapped ? 2'b00 : 2'b11;  // Decode error
        end
    end

    // ****************************************************************
    // Channels
    // ****************************************************************
    wire logic [FS_W-1:0] fs_lo = fstep_lv_q[FS_W-1:0];
    wire logic [FS_W-1:0] fs_hi = fstep_lv_q[7:FSTEP_HI_LSB];

    // Channel 0, lower half of the fine-step pair
    pwm_channel u_ch0 (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .count     (count_q),
        .weight    (weight_lv_q[0][PW_W-1:0]),
        .fine_step (fs_lo),
        .pol_inv   (weight_lv_q[0][WEIGHT_POL_BIT]),
        .pwm_out   (pwm_out[0])
    );

    // Channel 1, upper half of the fine-step pair
    pwm_channel u_ch1 (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .count     (count_q),
        .weight    (weight_lv_q[1][PW_W-1:0]),
        .fine_step (fs_hi),
        .pol_inv   (weight_lv_q[1][WEIGHT_POL_BIT]),
        .pwm_out   (pwm_out[1])
    );

endmodule : pwm_dac

// File: bench/pwm_dac_monitor.sv
// Checker for the DAC block, watching only the top ports.
// Assumes it is bound into pwm_dac from the bench top file.
`timescale 1ns/1ps
module pwm_dac_chk
    import pwm_dac_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              nrst,
    input wire logic [3:0]        avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic [1:0]        avs_response,
    input wire logic [NUM_CH-1:0] pwm_out
);
    logic rd_ok;   // Read taken at this edge
    logic seen_q;  // Some write taken since reset
    assign rd_ok = avs_read && !avs_waitrequest;
    // Remember the first accepted write
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) seen_q <= 1'b0;
        else if (avs_write && !avs_waitrequest) seen_q <= 1'b1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_rst_low; $rose(nrst) |-> pwm_out == '0; endproperty
    a_rst_low: assert property (p_rst_low)
        else $error("pins not low after reset");
    property p_idle_low; !seen_q |-> pwm_out == '0; endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("pin pulsed with zero settings");
    property p_bit7;
        rd_ok && !avs_address[3] && avs_address[1:0] == 2'b00
            |-> avs_readdata[7];
    endproperty
    a_bit7: assert property (p_bit7)
        else $error("weight bit 7 read as zero");
    property p_cnt_w; rd_ok && avs_address == OFF_COUNT
        |-> avs_readdata[31:10] == '0; endproperty
    a_cnt_w: assert property (p_cnt_w)
        else $error("counter wider than ten bits");
    property p_upper; rd_ok && avs_address != OFF_COUNT
        |-> avs_readdata[31:8] == '0; endproperty
    a_upper: assert property (p_upper)
        else $error("byte register upper bits set");
    property p_unmap; rd_ok && avs_address[1:0] != 2'b00
        |-> avs_readdata == '0 && avs_response == 2'b11; endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not refused");
    property p_mapped; rd_ok && avs_address[1:0] == 2'b00
        |-> avs_response == 2'b00; endproperty
    a_mapped: assert property (p_mapped)
        else $error("mapped read not ok");
    property p_wait; $rose(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_wait: assert property (p_wait)
        else $error("request not answered after one wait");
endmodule : pwm_dac_chk

// File: bench/rc_load.sv
// Behavioural RC load on both pins: charge counts clocks high.
// Assumes pins change only just after the rising clock edge.
`timescale 1ns/1ps
module rc_load (
    input  wire logic        sys_clk,
    input  wire logic        clr,   // Discharge both capacitors
    input  wire logic [1:0]  pin,   // Pin levels from the DAC
    output logic      [31:0] hi0,   // Charge on channel 0
    output logic      [31:0] hi1    // Charge on channel 1
);
    // Charge grows one step per clock the pin is high
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            hi0 <= 32'h0;
            hi1 <= 32'h0;
        end else begin
            hi0 <= hi0 + {31'h0, pin[0]};
            hi1 <= hi1 + {31'h0, pin[1]};
        end
    end
endmodule : rc_load

// File: bench/tb_top.sv
// Bench: register access over Avalon-MM and averaged pin levels.
// Assumes the DAC, its checker and the RC load model are compiled.
`timescale 1ns/1ps
module tb_top
    import pwm_dac_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic        clr = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q, hi0, hi1;
    logic [1:0]  avs_response, r, pwm_out;
    logic        avs_waitrequest;
    int          n_mismatch = 0;
    int          tests_run = 0;
    // Per case: weights, fine-step pair, expected clocks high
    logic [7:0]  wt0 [4] = '{8'h00, 8'h3f, 8'h05, 8'h0a};
    logic [7:0]  wt1 [4] = '{8'h40, 8'h18, 8'h45, 8'h01};
    logic [7:0]  fs  [4] = '{8'h00, 8'h6f, 8'h21, 8'h84};
    logic [31:0] e0  [4] = '{32'h0, 32'h3ff, 32'h51, 32'ha4};
    logic [31:0] e1  [4] = '{32'h400, 32'h186, 32'h3ae, 32'h18};
    pwm_dac dut (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .avs_response, .pwm_out);
    rc_load load (.sys_clk, .clr, .pin(pwm_out), .hi0, .hi1);
    always #12.5 sys_clk = ~sys_clk;
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, input logic [3:0] b);
        int n;
        @(posedge sys_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= b;
        n = 0;
        // Waitrequest and read data are taken at the same rising edge
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        r = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 50) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : bus
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        chk("pins", 32'h0, {30'h0, pwm_out});
        bus(1'b0, OFF_WEIGHT0, 8'h00, 4'hf);
        chk("w0 reset", 32'h80, q);
        bus(1'b0, OFF_FSTEP, 8'h00, 4'hf);
        chk("fs reset", 32'h00, q);
        bus(1'b1, OFF_WEIGHT1, 8'h00, 4'hf);
        bus(1'b0, OFF_WEIGHT1, 8'h00, 4'hf);
        chk("w1 bit7", 32'h80, q);
        bus(1'b1, OFF_WEIGHT0, 8'h3f, 4'h0);
        bus(1'b0, OFF_WEIGHT0, 8'h00, 4'hf);
        chk("w0 lane off", 32'h80, q);
        bus(1'b0, 4'h2, 8'h00, 4'hf);
        chk("unmapped", 32'h3, {30'h0, r});
        bus(1'b0, OFF_COUNT, 8'h00, 4'hf);
        chk("count resp", 32'h0, {30'h0, r});
        $display("Register test done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, OFF_WEIGHT0, wt0[i], 4'hf);
            bus(1'b1, OFF_WEIGHT1, wt1[i], 4'hf);
            bus(1'b1, OFF_FSTEP, fs[i], 4'hf);
            bus(1'b0, OFF_FSTEP, 8'h00, 4'hf);
            chk("fs read", {24'h0, fs[i]}, q);
            repeat (1100) @(posedge sys_clk);
            clr <= 1'b1;
            @(posedge sys_clk);
            clr <= 1'b0;
            repeat (1024) @(posedge sys_clk);
            @(negedge sys_clk);
            chk("ch0 high", e0[i], hi0);
            chk("ch1 high", e1[i], hi1);
            $display("Level case %0d done", i);
        end
        wrap_up();
    end
    // Watchdog: four cases take about nine thousand clocks
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        wrap_up();
    end
endmodule : tb_top
bind pwm_dac pwm_dac_chk chk (.sys_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .pwm_out);
